/* File: hdl/flc_pkg.sv */
// Constants, types and field layouts of the four-bit LCD microcontroller core
package flc_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ       = 50_000_000;
   localparam int XT_FREQ_HZ   = 32_768;
   localparam int XT_HALF_CYC  = CLK_HZ / (2 * XT_FREQ_HZ);
   localparam int MCYC_NS      = 122_100;
   localparam int MCYC_XT      = 4;
   localparam int XT_DIV_W     = 15;
   localparam int TAP_32HZ_BIT = 9;
   localparam int LCD_STEP_W   = 7;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int PC_W      = 10;
   localparam int ROM_DEPTH = 1024;
   localparam int IW        = 14;
   localparam int RAM_DEPTH = 64;
   localparam int RAM_USED  = 62;
   localparam int SEG_N     = 60;
   localparam int DIG_N     = 30;
   localparam int AXI_AW    = 8;

   // -----------------------------------------------------------------
   // Register map and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_RADR = 8'h08;
   localparam logic [7:0] OFS_RDAT = 8'h0c;
   localparam logic [7:0] OFS_PORT = 8'h10;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [9:0] PC_RST   = 10'h000;
   localparam logic [3:0] NIB_RST  = 4'h0;

   // LCD drive level codes
   localparam logic [1:0] LCD_LO  = 2'h0;
   localparam logic [1:0] LCD_MID = 2'h1;
   localparam logic [1:0] LCD_HI  = 2'h2;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_MISC = 4'h0, OP_ADD  = 4'h1, OP_ADDI = 4'h2, OP_SUB = 4'h3,
      OP_SUBI = 4'h4, OP_CMP  = 4'h5, OP_LDA  = 4'h6, OP_STA = 4'h7,
      OP_LDI  = 4'h8, OP_PAGE = 4'h9, OP_IN1  = 4'ha, OP_IN2 = 4'hb,
      OP_MTX  = 4'hc, OP_DSP  = 4'hd, OP_JMP  = 4'he, OP_BRZ = 4'hf
   } flc_op_t;

   typedef struct packed {
      flc_op_t    op;
      logic       p0;
      logic       ext;
      logic [3:0] imm;
      logic [3:0] col;
   } flc_insn_t;

   typedef struct packed {
      logic soft_clr;
      logic run;
   } flc_ctrl_t;

endpackage

/* File: hdl/flc_core.sv */
// Four-bit LCD microcontroller core with AXI4-Lite program and status access
`timescale 1ns/1ps
module flc_core
   import flc_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address and data
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Pins
   input  wire logic [3:0]        first_input_port,
   input  wire logic [1:0]        key_input_port,
   input  wire logic              logic_clear_in,
   output logic [3:0]             matrix_output_port,
   output logic                   matrix_strobe_out,
   output logic                   buzzer_out,
   output logic                   lamp_out,
   output logic                   external_reset_out,
   output logic                   crystal_clock_out,
   // LCD drive
   output logic [SEG_N-1:0]       lcd_segment_out,
   output logic [1:0]             lcd_backplane_one,
   output logic [1:0]             lcd_backplane_two
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [6:0] pin_meta_r;
   logic [6:0] pin_sync_r;

   always_ff @(posedge aclk) begin
      pin_meta_r <= {logic_clear_in, key_input_port, first_input_port};
      pin_sync_r <= pin_meta_r;
   end

   wire [3:0] s1_pins  = pin_sync_r[3:0];
   wire [1:0] key_pins = pin_sync_r[5:4];
   wire       clr_pin  = pin_sync_r[6];

   // ------------------------------------------------------------------
   // Control register and core clear
   // ------------------------------------------------------------------
   flc_ctrl_t ctrl_r;
   logic      core_clr;

   assign core_clr = ~aresetn | clr_pin | ctrl_r.soft_clr;

   // ------------------------------------------------------------------
   // Crystal time base and divider chain
   // ------------------------------------------------------------------
   logic [9:0]          xt_half_r;
   logic                xt_phase_r;
   logic [XT_DIV_W-1:0] xt_div_r;
   logic [1:0]          mc_div_r;
   logic                xt_half_end;
   logic                xt_tick;
   logic                mcyc_en;
   logic                lcd_step;

   assign xt_half_end = (xt_half_r == 10'(XT_HALF_CYC - 1));
   assign xt_tick     = xt_half_end & xt_phase_r;
   assign mcyc_en     = xt_tick & (mc_div_r == 2'(MCYC_XT - 1));
   assign lcd_step    = xt_tick & (xt_div_r[LCD_STEP_W-1:0] == '0);

   always_ff @(posedge aclk) begin
      if (core_clr) begin
         xt_half_r         <= '0;
         xt_phase_r        <= 1'b0;
         xt_div_r          <= '0;
         mc_div_r          <= '0;
         crystal_clock_out <= 1'b0;
      end else begin
         xt_half_r <= xt_half_end ? '0 : xt_half_r + 10'h001;
         if (xt_half_end) begin
            xt_phase_r        <= ~xt_phase_r;
            crystal_clock_out <= ~xt_phase_r;
         end
         if (xt_tick) begin
            xt_div_r <= xt_div_r + 15'h0001;
            mc_div_r <= mc_div_r + 2'h1;
         end
      end
   end

   // 1 Hz to 32 Hz square-wave taps
   wire [5:0] tap_bits = xt_div_r[XT_DIV_W-1:TAP_32HZ_BIT];

   // ------------------------------------------------------------------
   // Program memory and fetch
   // ------------------------------------------------------------------
   logic [IW-1:0]   rom_mem [ROM_DEPTH];
   logic [PC_W-1:0] program_counter;
   logic [PC_W-1:0] rom_addr_r;
   logic            rom_we;
   logic [IW-1:0]   rom_wdata;
   flc_insn_t       insn;

   assign insn = flc_insn_t'(rom_mem[program_counter]);

   always_ff @(posedge aclk) begin
      if (rom_we) begin
         rom_mem[rom_addr_r] <= rom_wdata;
      end
   end

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   wire       exec     = mcyc_en & ctrl_r.run;
   wire [1:0] page_sel;
   wire [5:0] ram_addr;
   wire [4:0] dig_idx  = {insn.ext, insn.imm};
   wire       is_arith;
   wire       is_sub;
   wire       use_imm;

   logic [1:0] page_r;
   logic [3:0] work_nibble_reg;
   logic       null_result_flag;
   logic       overflow_out_flag;

   assign page_sel = insn.p0 ? 2'h0 : page_r;
   assign ram_addr = {page_sel, insn.col};
   assign is_arith = (insn.op inside {OP_ADD, OP_ADDI, OP_SUB, OP_SUBI, OP_CMP});
   assign is_sub   = (insn.op inside {OP_SUB, OP_SUBI, OP_CMP});
   assign use_imm  = (insn.op inside {OP_ADDI, OP_SUBI});

   // ------------------------------------------------------------------
   // Data memory and ALU
   // ------------------------------------------------------------------
   logic [3:0] ram_mem [RAM_DEPTH];
   wire        ram_ok  = (ram_addr < 6'(RAM_USED));
   wire [3:0]  ram_rd  = ram_ok ? ram_mem[ram_addr] : NIB_RST;
   wire [3:0]  alu_b   = use_imm ? insn.imm : work_nibble_reg;
   wire [4:0]  alu_sum = {1'b0, ram_rd} + {1'b0, alu_b};
   wire [4:0]  alu_dif = {1'b0, ram_rd} - {1'b0, alu_b};
   wire [4:0]  alu_res = is_sub ? alu_dif : alu_sum;

   logic [3:0] ram_wd;
   logic       ram_we;

   always_comb begin
      ram_wd = alu_res[3:0];
      ram_we = 1'b0;
      unique case (insn.op)
         OP_ADD, OP_ADDI, OP_SUB, OP_SUBI: ram_we = 1'b1;
         OP_STA: begin
            ram_wd = work_nibble_reg;
            ram_we = 1'b1;
         end
         OP_IN1: begin
            ram_wd = s1_pins;
            ram_we = 1'b1;
         end
         OP_IN2: begin
            ram_wd = {2'h0, key_pins};
            ram_we = 1'b1;
         end
         default: ram_we = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (exec & ram_we & ram_ok & ~core_clr) begin
         ram_mem[ram_addr] <= ram_wd;
      end
   end

   // ------------------------------------------------------------------
   // Execute: program counter, work nibble, flags, page
   // ------------------------------------------------------------------
   logic [PC_W-1:0] pc_nxt;
   wire  [PC_W-1:0] target = {insn.p0, insn.ext, insn.imm, insn.col};

   always_comb begin
      pc_nxt = program_counter + 10'h001;
      if (insn.op == OP_JMP) begin
         pc_nxt = target;
      end else if (insn.op == OP_BRZ && null_result_flag) begin
         pc_nxt = target;
      end
   end

   always_ff @(posedge aclk) begin
      if (core_clr) begin
         program_counter   <= PC_RST;
         work_nibble_reg   <= NIB_RST;
         null_result_flag  <= 1'b0;
         overflow_out_flag <= 1'b0;
         page_r            <= 2'h0;
      end else if (exec) begin
         program_counter <= pc_nxt;
         if (is_arith) begin
            null_result_flag  <= (alu_res[3:0] == 4'h0);
            overflow_out_flag <= alu_res[4];
         end
         if (insn.op == OP_LDA) begin
            work_nibble_reg <= ram_rd;
         end
         if (insn.op == OP_LDI) begin
            work_nibble_reg <= insn.imm;
         end
         if (insn.op == OP_MISC && insn.ext) begin
            work_nibble_reg <= insn.imm[0] ? {2'h0, tap_bits[1:0]} : tap_bits[5:2];
         end
         if (insn.op == OP_PAGE) begin
            page_r <= insn.imm[1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Output latches: matrix, buzzer, lamp, external reset
   // ------------------------------------------------------------------
   logic ext_rst_bit_r;

   always_ff @(posedge aclk) begin
      if (core_clr) begin
         matrix_output_port <= NIB_RST;
         matrix_strobe_out  <= 1'b0;
         buzzer_out         <= 1'b0;
         lamp_out           <= 1'b0;
         ext_rst_bit_r      <= 1'b0;
      end else begin
         matrix_strobe_out <= exec & (insn.op == OP_MTX);
         if (exec & (insn.op == OP_MTX)) begin
            matrix_output_port <= ram_rd;
         end
         if (exec & (insn.op == OP_MISC) & insn.p0) begin
            buzzer_out    <= insn.imm[0];
            lamp_out      <= insn.imm[1];
            ext_rst_bit_r <= insn.imm[2];
         end
      end
   end

   always_ff @(posedge aclk) begin
      external_reset_out <= core_clr | ext_rst_bit_r;
   end

   // ------------------------------------------------------------------
   // Display latch and half-duty, half-bias multiplexer
   // ------------------------------------------------------------------
   logic [2*SEG_N-1:0] disp_r;
   logic [1:0]         lcd_ph_r;
   wire                lcd_lcd_backplane_two = lcd_ph_r[1];
   wire                lcd_pol  = lcd_ph_r[0];
   wire [1:0]          com_act  = lcd_pol ? LCD_HI : LCD_LO;
   wire [SEG_N-1:0]    seg_on;
   wire [SEG_N-1:0]    seg_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < SEG_N; gi++) begin : g_seg
         assign seg_on[gi]  = disp_r[2*gi + (lcd_lcd_backplane_two ? 1 : 0)];
         assign seg_nxt[gi] = seg_on[gi] ? ~lcd_pol : lcd_pol;
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (core_clr) begin
         disp_r            <= '0;
         lcd_ph_r          <= 2'h0;
         lcd_segment_out   <= '0;
         lcd_backplane_one <= LCD_MID;
         lcd_backplane_two <= LCD_MID;
      end else begin
         if (exec & (insn.op == OP_DSP) & (dig_idx < 5'(DIG_N))) begin
            disp_r[4*dig_idx +: 4] <= ram_rd;
         end
         if (lcd_step) begin
            lcd_ph_r <= lcd_ph_r + 2'h1;
         end
         lcd_segment_out   <= seg_nxt;
         lcd_backplane_one <= lcd_lcd_backplane_two ? LCD_MID : com_act;
         lcd_backplane_two <= lcd_lcd_backplane_two ? com_act : LCD_MID;
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------------
   logic [AXI_AW-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;

   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   wire        aw_hs  = s_axi_awvalid & s_axi_awready;
   wire        w_hs   = s_axi_wvalid & s_axi_wready;
   wire        do_wr  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire        wr_ctl = do_wr & (awaddr_r == OFS_CTRL);
   wire        wr_adr = do_wr & (awaddr_r == OFS_RADR);
   wire        wr_dat = do_wr & (awaddr_r == OFS_RDAT);
   wire        wr_ro  = do_wr & ((awaddr_r == OFS_STAT) | (awaddr_r == OFS_PORT));
   wire        wr_hit = wr_ctl | wr_adr | wr_dat | wr_ro;
   wire [31:0] ctl_m  = strb_merge({30'h0, ctrl_r}, wdata_r, wstrb_r);
   wire [31:0] adr_m  = strb_merge({22'h0, rom_addr_r}, wdata_r, wstrb_r);
   wire [31:0] dat_m  = strb_merge({18'h0, rom_mem[rom_addr_r]}, wdata_r, wstrb_r);

   assign rom_we    = wr_dat;
   assign rom_wdata = dat_m[IW-1:0];

   always_ff @(posedge aclk) begin
      if (~aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
         ctrl_r        <= '0;
         rom_addr_r    <= '0;
      end else begin
         if (aw_hs) begin
            s_axi_awready <= 1'b0;
            awaddr_r      <= s_axi_awaddr;
         end
         if (w_hs) begin
            s_axi_wready <= 1'b0;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (wr_ctl) begin
            ctrl_r <= flc_ctrl_t'(ctl_m[1:0]);
         end
         if (wr_adr) begin
            rom_addr_r <= adr_m[PC_W-1:0];
         end else if (wr_dat & (|wstrb_r[1:0])) begin
            rom_addr_r <= rom_addr_r + 10'h001;
         end
      end
   end

   // Read decode
   wire [31:0] stat_v = {10'h0, page_r, work_nibble_reg, 2'h0,
                         overflow_out_flag, null_result_flag, 2'h0, program_counter};
   wire [31:0] port_v = {18'h0, external_reset_out, lamp_out, buzzer_out,
                         matrix_strobe_out, key_pins, s1_pins, matrix_output_port};
   wire        rd_ctl = (s_axi_araddr == OFS_CTRL);
   wire        rd_sta = (s_axi_araddr == OFS_STAT);
   wire        rd_adr = (s_axi_araddr == OFS_RADR);
   wire        rd_dat = (s_axi_araddr == OFS_RDAT);
   wire        rd_prt = (s_axi_araddr == OFS_PORT);
   wire        rd_hit = rd_ctl | rd_sta | rd_adr | rd_dat | rd_prt;
   wire [31:0] rd_v   = ({32{rd_ctl}} & {30'h0, ctrl_r})
                      | ({32{rd_sta}} & stat_v)
                      | ({32{rd_adr}} & {22'h0, rom_addr_r})
                      | ({32{rd_dat}} & {18'h0, rom_mem[rom_addr_r]})
                      | ({32{rd_prt}} & port_v);
   wire        ar_hs  = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge aclk) begin
      if (~aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_v;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

/* File: verification/flc_core_properties.sv */
// Concurrent checks on the pins and register bus of the core
`timescale 1ns/1ps
module flc_core_properties
   import flc_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Pins
   input wire logic        logic_clear_in,
   input wire logic [3:0]  matrix_output_port,
   input wire logic        matrix_strobe_out,
   input wire logic        external_reset_out,
   input wire logic        crystal_clock_out,
   input wire logic [1:0]  lcd_backplane_one,
   input wire logic [1:0]  lcd_backplane_two
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------------------------
   // Cycles since the last crystal output edge
   // ---------------------------------------------------------------
   logic [9:0] xt_cnt_r;
   logic       xt_seen_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || external_reset_out) begin
         xt_cnt_r  <= 10'h000;
         xt_seen_r <= 1'b0;
      end else if ($changed(crystal_clock_out)) begin
         xt_cnt_r  <= 10'h000;
         xt_seen_r <= 1'b1;
      end else begin
         xt_cnt_r <= xt_cnt_r + 10'h001;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels ready during response");
   a_write_done: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   a_read_done: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid && s_axi_arready) else $error("read not closed");
   a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h13
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
   a_strobe_pulse: assert property ($rose(matrix_strobe_out) |=> !matrix_strobe_out)
      else $error("strobe longer than one cycle");
   a_matrix_hold: assert property ($changed(matrix_output_port) |->
      matrix_strobe_out || external_reset_out) else $error("matrix changed without load");
   a_clear_out: assert property (logic_clear_in [*6] |->
      external_reset_out && matrix_output_port == 4'h0) else $error("clear not applied");
   a_xt_period: assert property (xt_seen_r && $changed(crystal_clock_out) |->
      xt_cnt_r == 10'(XT_HALF_CYC - 1)) else $error("crystal output period wrong");
   a_half_duty: assert property (lcd_backplane_one != LCD_MID |->
      lcd_backplane_two == LCD_MID) else $error("both backplanes active");
endmodule

bind flc_core flc_core_properties i_props (
   .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .logic_clear_in, .matrix_output_port,
   .matrix_strobe_out, .external_reset_out, .crystal_clock_out, .lcd_backplane_one,
   .lcd_backplane_two
);

/* File: verification/flc_pad_model.sv */
// Switches, keys and clear pin at the far side of the core
`timescale 1ns/1ps
module flc_pad_model (
   // Clock
   input  wire logic       aclk,
   // Requests from the bench
   input  wire logic [3:0] sw_req,
   input  wire logic [1:0] key_req,
   input  wire logic       clr_req,
   // Pins
   output logic [3:0]      first_input_port = 4'h0,
   output logic [1:0]      key_input_port = 2'h0,
   output logic            logic_clear_in = 1'b1,
   input  wire logic       matrix_strobe_out,
   // Count of matrix load pulses
   output int              strobes = 0
);
   int n_up = 0;
   // Clear after power-up, then on request
   always @(posedge aclk) begin
      if (n_up < 32) n_up <= n_up + 1;
      logic_clear_in   <= (n_up < 32) || clr_req;
      first_input_port <= sw_req;
      key_input_port   <= key_req;
      if (matrix_strobe_out) strobes <= strobes + 1;
   end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the four-bit LCD microcontroller core
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      checks_done++; \
      if ((g) !== (e)) begin \
         n_mismatch++; \
         $display("BAD %0t got %h exp %h", $time, g, e); \
      end \
   end
module tb_top
   import flc_pkg::*;
;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h0d9c, rd_d;
   logic [3:0]  s_axi_wstrb = 4'hf, sw_req = 4'h0, first_input_port, matrix_output_port, a, b, s;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clr_req = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        logic_clear_in, matrix_strobe_out, buzzer_out, lamp_out;
   logic        external_reset_out, crystal_clock_out;
   logic [1:0]  s_axi_bresp, s_axi_rresp, key_input_port, lcd_backplane_one, lcd_backplane_two;
   logic [1:0]  key_req = 2'h0, k, rsp;
   logic [59:0] lcd_segment_out;
   logic [4:0]  sm;
   logic [9:0]  last_pc;
   logic [13:0] prog [12];
   int          n_mismatch = 0, checks_done = 0, strobes;
   time         t_last = 0;

   always #10 aclk = ~aclk;

   flc_core i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .first_input_port, .key_input_port,
      .logic_clear_in, .matrix_output_port, .matrix_strobe_out, .buzzer_out, .lamp_out,
      .external_reset_out, .crystal_clock_out, .lcd_segment_out, .lcd_backplane_one,
      .lcd_backplane_two
   );
   flc_pad_model i_pads (
      .aclk, .sw_req, .key_req, .clr_req, .first_input_port, .key_input_port,
      .logic_clear_in, .matrix_strobe_out, .strobes
   );
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [13:0] ins(input flc_op_t op, input logic [7:0] ic);
      return {op, 2'b00, ic};
   endfunction
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic give_up();
      n_mismatch++;
      finish_test();
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= ad;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) give_up();
      `CHK(s_axi_bresp, er)
   endtask
   task automatic rd(input logic [7:0] ad);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      rd_d = s_axi_rdata;
      rsp  = s_axi_rresp;
      if (n == 50) give_up();
   endtask
   // Poll the status word until the next instruction has run
   task automatic step(input logic [9:0] pc);
      int n;
      int dt;
      int mc;
      mc = MCYC_XT * 2 * XT_HALF_CYC;
      for (n = 0; n < 3000; n++) begin
         rd(OFS_STAT);
         if (rd_d[9:0] !== last_pc) break;
      end
      if (n == 3000) give_up();
      dt = int'(($time - t_last) / 20);
      `CHK(rd_d[9:0], pc)
      if (t_last > 0) `CHK(dt > mc - 8 && dt < mc + 8, 1'b1)
      last_pc = rd_d[9:0];
      t_last = $time;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (48) @(posedge aclk);
      rd(OFS_STAT);
      `CHK(rd_d[9:0], PC_RST)
      rd(8'h40);
      `CHK(rsp, RESP_SLVERR)
      wr(8'h44, 32'h1, RESP_SLVERR);
      rnd = lfsr(lfsr(rnd));
      {k, s, b, a} = rnd[13:0];
      sm = {1'b0, a} + {1'b0, b};
      sw_req  <= s;
      key_req <= k;
      prog = '{ins(OP_LDI, {a, 4'h0}), ins(OP_STA, 8'h00), ins(OP_ADDI, {b, 4'h0}),
         ins(OP_LDA, 8'h00), ins(OP_MTX, 8'h00), ins(OP_IN1, 8'h01), ins(OP_LDA, 8'h01),
         ins(OP_IN2, 8'h02), ins(OP_LDA, 8'h02), {OP_MISC, 2'b10, 8'h70},
         ins(OP_DSP, 8'h00), {OP_JMP, 10'h3fe}};
      wr(OFS_RADR, 32'h0, RESP_OKAY);
      foreach (prog[i]) wr(OFS_RDAT, {18'h0, prog[i]}, RESP_OKAY);
      wr(OFS_RADR, 32'h2, RESP_OKAY);
      rd(OFS_RDAT);
      `CHK(rd_d, {18'h0, prog[2]})
      last_pc = 10'h000;
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      step(10'h001);
      `CHK(rd_d[19:16], a)
      step(10'h002);
      step(10'h003);
      `CHK(rd_d[13:12], {sm[4], sm[3:0] == 4'h0})
      step(10'h004);
      `CHK(rd_d[19:16], sm[3:0])
      step(10'h005);
      `CHK(matrix_output_port, sm[3:0])
      `CHK(strobes, 1)
      step(10'h006);
      sw_req <= ~s;
      step(10'h007);
      `CHK(rd_d[19:16], s)
      step(10'h008);
      step(10'h009);
      `CHK(rd_d[19:16], {2'b00, k})
      step(10'h00a);
      `CHK({external_reset_out, lamp_out, buzzer_out}, 3'h7)
      step(10'h00b);
      `CHK({lcd_backplane_one, lcd_segment_out[1:0]}, {LCD_HI, ~sm[2], ~sm[0]})
      step(10'h3fe);
      clr_req <= 1'b1;
      repeat (8) @(posedge aclk);
      `CHK({external_reset_out, matrix_output_port}, 5'h10)
      rd(OFS_STAT);
      `CHK(rd_d[9:0], PC_RST)
      clr_req <= 1'b0;
      last_pc = 10'h000;
      t_last = 0;
      step(10'h001);
      finish_test();
   end
endmodule
